/* File: hw/ofcd_pkg.sv */
// constants for the octal flash command decoder
package ofcd_pkg;
	localparam logic [7:0] OP_BOOT_RD      = 8'h16;
	localparam logic [7:0] OP_BOOT_WR      = 8'h17;
	localparam logic [7:0] OP_BOOT_ER      = 8'h18;
	localparam logic [7:0] OP_SLEEP_ENTER  = 8'hB9;
	localparam logic [7:0] OP_SLEEP_EXIT   = 8'hAB;
	localparam logic [7:0] OP_RESET_ARM    = 8'h66;
	localparam logic [7:0] OP_RESET_MEM    = 8'h99;
	localparam logic [7:0] OP_IDENT_RD     = 8'h9F;
	localparam logic [7:0] OP_STATUS_RD    = 8'h05;
	localparam logic [7:0] OP_CONFIG_RD    = 8'h15;
	localparam logic [7:0] OP_SECUR_RD     = 8'h2B;
	localparam logic [7:0] OP_LOCK_RD      = 8'h2D;
	localparam logic [7:0] OP_PERS_PROT_RD = 8'hE2;
	localparam logic [7:0] OP_DYN_PROT_RD  = 8'hE0;
	localparam logic [7:0] OP_WRITE_EN     = 8'h06;
	localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
	localparam logic [7:0] OP_PAGE_PROG    = 8'h12;
	localparam logic [7:0] OP_SECT_ERASE   = 8'h21;
	localparam logic [7:0] OP_SUSPEND      = 8'hB0;
	localparam logic [7:0] OP_RESUME       = 8'h30;
	localparam int         ADDR_BYTES      = 4;
	localparam int         REG_DUMMY       = 4;
	localparam logic [4:0] PROT_DUMMY_MIN  = 5'd6;
	localparam logic [4:0] PROT_DUMMY_MAX  = 5'd20;
	localparam int         IDENT_BYTES     = 3;
	localparam int         BOOT_WR_BYTES   = 4;
	localparam int         BOOT_RD_MAX     = 4;
	localparam int         BUSY_BIT        = 0;
	localparam int         LATCH_BIT       = 1;
	// program/erase busy time in link cycles
	localparam int         BUSY_CYCLES     = 64;
	// identity value is arbitrary
	localparam logic [23:0] IDENT_VALUE    = 24'hA5_5A_01;
	localparam logic [31:0] BOOT_RESET     = 32'hFFFF_FFFF;

	typedef enum logic [3:0] {
		OFCD_OPC = 4'h0, OFCD_NONE, OFCD_BOOT_RD, OFCD_BOOT_WR, OFCD_BOOT_ER,
		OFCD_SLEEP_IN, OFCD_SLEEP_OUT, OFCD_RST_ARM, OFCD_RST_MEM, OFCD_IDENT,
		OFCD_REG_RD, OFCD_PROT_RD, OFCD_WEN, OFCD_WDIS, OFCD_PROG, OFCD_ERASE
	} ofcd_cmd_t;
endpackage : ofcd_pkg

/* File: hw/ofcd_sync.sv */
// two-flop synchroniser for levels into the system clock
`timescale 1ns/100ps
`default_nettype none
module ofcd_sync #(parameter int W = 1)
(
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] stage;

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			stage <= '0;
			o_q   <= '0;
		end
		else
		begin
			stage <= i_d;
			o_q   <= stage;
		end
	end
endmodule : ofcd_sync
`default_nettype wire

/* File: hw/ofcd_decoder.sv */
// octal flash command decoder, link side on the serial clock
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - boot register read is 16h/E9h, four zero address bytes, four dummies, one to four bytes out.
// - boot register write is 17h/E8h, four zero address bytes, no dummies, four bytes in.
// - boot register erase is 18h/E7h with no address, dummy or data.
// - deep sleep entry B9h/46h and exit ABh/54h are opcode only in either rate.
// - a memory reset counts only when the reset arm command came directly before it.
// - status, config, security, lock and boot register reads take four dummy cycles.
// - identity read returns three bytes and boot read returns data at single rate always.
// - protection-bit reads use six to twenty dummies from the configured setting.
// - program and erase are ignored without the write latch, which clears on completion.
// - status bit zero is the busy flag while program or erase runs.
module ofcd_decoder
(
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	input  wire logic               i_sclk,
	input  wire logic               i_cs_n,
	input  wire logic [7:0]         i_dq,
	input  wire logic               i_dtr_mode,
	input  wire logic [4:0]         i_prot_dummy,
	output logic      [7:0]         o_dq,
	output logic                    o_dq_oe,
	output logic                    o_single_rate,
	output logic                    o_deep_sleep,
	output logic                    o_busy_flag,
	output logic                    o_write_latch,
	output logic                    o_mem_reset,
	output logic      [31:0]        o_boot_reg
);
	import ofcd_pkg::*;

	typedef enum logic [2:0] {
		OFCD_IDLE, OFCD_OP2, OFCD_ADDR, OFCD_DUMMY, OFCD_DIN, OFCD_DOUT, OFCD_IGNORE
	} ofcd_phase_t;

	typedef struct packed {
		ofcd_phase_t phase;
		ofcd_cmd_t   cmd;
		logic [7:0]  op1;
		logic [2:0]  cnt;
		logic [4:0]  dummy;
		logic [2:0]  bytes;
		logic [31:0] shift;
		logic        armed;
		logic        latch;
		logic [6:0]  busy_cnt;
		logic        sleep;
		logic [31:0] boot;
		logic        rst_tgl;
		logic [7:0]  dq;
		logic        oe;
		logic        str;
		logic [5:0]  cfg_meta;
		logic [5:0]  cfg;
	} ofcd_link_t;

	ofcd_link_t r;
	ofcd_link_t next_r;
	logic [4:0] prot_dummy;

	// clamp configured dummy count into its legal span
	assign prot_dummy = (r.cfg[4:0] < PROT_DUMMY_MIN) ? PROT_DUMMY_MIN :
		(r.cfg[4:0] > PROT_DUMMY_MAX) ? PROT_DUMMY_MAX : r.cfg[4:0];

	always_comb
	begin
		next_r = r;
		// mode and dummy setting come from another domain: two flops first
		next_r.cfg_meta = {i_dtr_mode, i_prot_dummy};
		next_r.cfg      = r.cfg_meta;
		if (r.busy_cnt != 7'd0)
		begin
			next_r.busy_cnt = r.busy_cnt - 7'd1;
			if (r.busy_cnt == 7'd1)
				next_r.latch = 1'b0;
		end
		case (r.phase)
			OFCD_IDLE:
			begin
				next_r.op1   = i_dq;
				// a frame cut after one byte must not replay the last command
				next_r.cmd   = OFCD_NONE;
				next_r.phase = OFCD_OP2;
				next_r.oe    = 1'b0;
			end
			OFCD_OP2:
			begin
				next_r.cmd   = OFCD_NONE;
				next_r.cnt   = 3'd0;
				next_r.bytes = 3'd0;
				next_r.phase = OFCD_IGNORE;
				next_r.str   = 1'b0;
				if (i_dq == ~r.op1)
				begin
					next_r.phase = OFCD_ADDR;
					if (r.op1 == OP_BOOT_RD)
						next_r.cmd = OFCD_BOOT_RD;
					else if (r.op1 == OP_BOOT_WR)
						next_r.cmd = OFCD_BOOT_WR;
					else if (r.op1 == OP_IDENT_RD)
						next_r.cmd = OFCD_IDENT;
					else if (r.op1 == OP_STATUS_RD || r.op1 == OP_CONFIG_RD ||
						r.op1 == OP_SECUR_RD || r.op1 == OP_LOCK_RD)
						next_r.cmd = OFCD_REG_RD;
					else if (r.op1 == OP_PERS_PROT_RD || r.op1 == OP_DYN_PROT_RD)
						next_r.cmd = OFCD_PROT_RD;
					else if (r.op1 == OP_PAGE_PROG || r.op1 == OP_SECT_ERASE)
						next_r.cmd = (r.op1 == OP_PAGE_PROG) ? OFCD_PROG : OFCD_ERASE;
					else
					begin
						next_r.phase = OFCD_IGNORE;
						if (r.op1 == OP_BOOT_ER)
							next_r.cmd = OFCD_BOOT_ER;
						else if (r.op1 == OP_SLEEP_ENTER)
							next_r.cmd = OFCD_SLEEP_IN;
						else if (r.op1 == OP_SLEEP_EXIT)
							next_r.cmd = OFCD_SLEEP_OUT;
						else if (r.op1 == OP_RESET_ARM)
							next_r.cmd = OFCD_RST_ARM;
						else if (r.op1 == OP_RESET_MEM)
							next_r.cmd = OFCD_RST_MEM;
						else if (r.op1 == OP_WRITE_EN)
							next_r.cmd = OFCD_WEN;
						else if (r.op1 == OP_WRITE_DIS)
							next_r.cmd = OFCD_WDIS;
					end
					// while asleep only the exit command is honoured
					if (r.sleep && r.op1 != OP_SLEEP_EXIT)
					begin
						next_r.cmd   = OFCD_NONE;
						next_r.phase = OFCD_IGNORE;
					end
				end
			end
			OFCD_ADDR:
			begin
				next_r.shift = {r.shift[23:0], i_dq};
				next_r.cnt   = r.cnt + 3'd1;
				if (r.cnt == 3'(ADDR_BYTES - 1))
				begin
					next_r.cnt   = 3'd0;
					next_r.phase = OFCD_DUMMY;
					// fixed four dummies on register reads
					if (r.cmd == OFCD_BOOT_RD || r.cmd == OFCD_REG_RD || r.cmd == OFCD_IDENT)
						next_r.dummy = 5'(REG_DUMMY);
					else if (r.cmd == OFCD_PROT_RD)
						next_r.dummy = prot_dummy;
					else
						next_r.phase = OFCD_DIN;
				end
			end
			OFCD_DUMMY:
			begin
				next_r.dummy = r.dummy - 5'd1;
				if (r.dummy == 5'd1)
				begin
					next_r.phase = OFCD_DOUT;
					next_r.oe    = 1'b1;
					// identity and boot reads always single rate
					next_r.str   = (r.cmd == OFCD_IDENT || r.cmd == OFCD_BOOT_RD) || !r.cfg[5];
					if (r.cmd == OFCD_IDENT)
						next_r.dq = IDENT_VALUE[23:16];
					else if (r.cmd == OFCD_BOOT_RD)
						next_r.dq = r.boot[7:0];
					else if (r.cmd == OFCD_REG_RD)
						next_r.dq = {6'h00, r.latch, r.busy_cnt != 7'd0};
					else
						next_r.dq = 8'h00;
				end
			end
			OFCD_DOUT:
			begin
				next_r.bytes = r.bytes + 3'd1;
				if (r.cmd == OFCD_IDENT && r.bytes < 3'(IDENT_BYTES - 1))
					next_r.dq = (r.bytes == 3'd0) ? IDENT_VALUE[15:8] : IDENT_VALUE[7:0];
				// boot read streams up to four bytes
				else if (r.cmd == OFCD_BOOT_RD && r.bytes < 3'(BOOT_RD_MAX - 1))
					next_r.dq = r.boot[8*(r.bytes+3'd1) +: 8];
				else
					next_r.dq = r.dq;
			end
			OFCD_DIN:
			begin
				next_r.shift = {i_dq, r.shift[31:8]};
				next_r.bytes = r.bytes + 3'd1;
			end
			default: next_r.phase = OFCD_IGNORE;
		endcase
		// frame end commits opcode-only and write commands
		if (i_cs_n)
		begin
			next_r.phase = OFCD_IDLE;
			next_r.oe    = 1'b0;
			next_r.armed = 1'b0;
			if (r.phase != OFCD_IDLE)
			begin
				case (r.cmd)
					OFCD_SLEEP_IN:  next_r.sleep = 1'b1;
					OFCD_SLEEP_OUT: next_r.sleep = 1'b0;
					OFCD_WEN:       next_r.latch = 1'b1;
					OFCD_WDIS:      next_r.latch = 1'b0;
					// reset arm must be directly before reset
					OFCD_RST_ARM:   next_r.armed = 1'b1;
					OFCD_RST_MEM:
						if (r.armed)
						begin
							next_r.rst_tgl  = ~r.rst_tgl;
							next_r.latch    = 1'b0;
							next_r.busy_cnt = 7'd0;
							next_r.sleep    = 1'b0;
						end
					// exactly four data bytes, write latch required
					OFCD_BOOT_WR:
						if (r.bytes == 3'(BOOT_WR_BYTES) && r.latch && r.busy_cnt == 7'd0)
						begin
							next_r.boot     = r.shift;
							next_r.busy_cnt = 7'(BUSY_CYCLES);
						end
					// ignored unless latch set, then busy
					OFCD_BOOT_ER, OFCD_PROG, OFCD_ERASE:
						if (r.latch && r.busy_cnt == 7'd0)
						begin
							if (r.cmd == OFCD_BOOT_ER)
								next_r.boot = BOOT_RESET;
							next_r.busy_cnt = 7'(BUSY_CYCLES);
						end
					default: next_r.armed = 1'b0;
				endcase
			end
			else
				next_r.armed = r.armed;
		end
	end

	always_ff @(posedge i_sclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			r       <= '0;
			r.phase <= OFCD_IDLE;
			r.cmd   <= OFCD_NONE;
			r.boot  <= BOOT_RESET;
		end
		else
			r <= next_r;
	end

	// link-side pins driven from link flops
	assign o_dq          = r.dq;
	assign o_dq_oe       = r.oe;
	assign o_single_rate = r.str;
	// status crosses into the system clock domain; boot is sent inverted so reset agrees
	logic [35:0] sync_q;
	logic [31:0] boot_seen;
	logic        rst_tgl_d;
	ofcd_sync #(.W(36)) u_sync
	(
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_d    ({r.sleep, r.busy_cnt != 7'd0, r.latch, r.rst_tgl, r.boot ^ BOOT_RESET}),
		.o_q    (sync_q)
	);
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rst_tgl_d     <= 1'b0;
			boot_seen     <= '0;
			o_deep_sleep  <= 1'b0;
			o_busy_flag   <= 1'b0;
			o_write_latch <= 1'b0;
			o_mem_reset   <= 1'b0;
			o_boot_reg    <= BOOT_RESET;
		end
		else
		begin
			rst_tgl_d     <= sync_q[32];
			boot_seen     <= sync_q[31:0];
			o_deep_sleep  <= sync_q[35];
			o_busy_flag   <= sync_q[34];
			o_write_latch <= sync_q[33];
			o_mem_reset   <= sync_q[32] ^ rst_tgl_d;
			// boot taken only when not busy and steady for two samples
			if (!sync_q[34] && sync_q[31:0] == boot_seen)
				o_boot_reg <= sync_q[31:0] ^ BOOT_RESET;
		end
	end
endmodule : ofcd_decoder
`default_nettype wire

/* File: testbench/ofcd_asserts.sv */
// port checker for the octal flash command decoder
`timescale 1ns/100ps
`default_nettype none
module ofcd_asserts
	import ofcd_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_sclk,
	input wire logic        i_cs_n,
	input wire logic [7:0]  i_dq,
	input wire logic        o_dq_oe,
	input wire logic        o_single_rate,
	input wire logic        o_busy_flag,
	input wire logic        o_write_latch,
	input wire logic        o_mem_reset,
	input wire logic [31:0] o_boot_reg
);
	logic [5:0] cnt;
	logic [7:0] op;
	// bytes taken so far in the frame and its first opcode
	always_ff @(posedge i_sclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt <= 6'h00;
			op  <= 8'h00;
		end
		else
		begin
			cnt <= i_cs_n ? 6'h00 : cnt + {5'h00, cnt != 6'h3F};
			if (!i_cs_n && cnt == 6'h00)
				op <= i_dq;
		end
	end
	oe_drop_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		i_cs_n |=> !o_dq_oe) else $error("drive held past frame");
	oe_frame_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		o_dq_oe |-> !$past(i_cs_n)) else $error("drive outside frame");
	dummy_gap_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		$rose(o_dq_oe) |-> cnt == 6'h0A || cnt >= 6'h0C) else $error("dummy count");
	narrow_out_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		o_dq_oe && (op == OP_IDENT_RD || op == OP_BOOT_RD) |-> o_single_rate)
		else $error("wide rate output");
	busy_hold_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		$rose(o_busy_flag) |=> o_busy_flag [*8]) else $error("busy too short");
	busy_end_a: assert property (@(posedge i_sclk) disable iff (i_rst)
		$rose(o_busy_flag) |-> ##[60:72] !o_busy_flag) else $error("busy length");
	pulse_once_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_mem_reset |=> !o_mem_reset) else $error("reset pulse long");
	latch_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_busy_flag) |-> $past(o_write_latch)) else $error("busy without latch");
	latch_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$fell(o_busy_flag) |-> ##[0:2] !o_write_latch) else $error("latch kept");
	boot_guard_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$changed(o_boot_reg) |-> $past(o_write_latch)) else $error("boot changed");
	cover property (@(posedge i_sclk) $rose(o_dq_oe));
	cover property (@(posedge i_mclk) $fell(o_busy_flag));
	cover property (@(posedge i_mclk) o_mem_reset);
endmodule : ofcd_asserts
bind ofcd_decoder ofcd_asserts u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(i_sclk),
	.i_cs_n(i_cs_n), .i_dq(i_dq), .o_dq_oe(o_dq_oe), .o_single_rate(o_single_rate),
	.o_busy_flag(o_busy_flag), .o_write_latch(o_write_latch),
	.o_mem_reset(o_mem_reset), .o_boot_reg(o_boot_reg));
`default_nettype wire

/* File: testbench/ofcd_host.sv */
// host controller model driving the octal link
`timescale 1ns/100ps
`default_nettype none
module ofcd_host
(
	output logic            o_sclk,
	output logic            o_cs_n,
	output logic      [7:0] o_dq,
	input  wire logic [7:0] i_dq,
	input  wire logic       i_oe
);
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_dq   = 8'h00;
	end
	// one link cycle; a released bus shows the inverse of its last value
	task automatic tick(input logic cs_n, input logic [7:0] d);
	begin
		o_cs_n = cs_n;
		o_dq = cs_n ? ~o_dq : d;
		// uneven halves keep the rise off the system clock edges
		#31 o_sclk = 1'b1;
		#33 o_sclk = 1'b0;
	end
	endtask : tick
	task automatic idle(input int n);
	begin
		repeat (n) tick(1'b1, 8'h00);
	end
	endtask : idle
	task automatic frame(input logic [7:0] op, input logic [7:0] op2, input int na,
		input int nw, input logic [31:0] wd, input int nd, input int nr,
		output logic [31:0] rd, output logic early);
		int i;
	begin
		rd = 32'h0;
		early = 1'b0;
		tick(1'b0, op);
		tick(1'b0, op2);
		// zero address keeps the start even
		repeat (na) tick(1'b0, 8'h00);
		for (i = 0; i < nw; i++)
			tick(1'b0, wd[8*i +: 8]);
		for (i = 1; i < nd; i++)
		begin
			tick(1'b0, 8'h00);
			early |= i_oe;
		end
		for (i = 0; i < nr; i++)
		begin
			tick(1'b0, 8'h00);
			rd = {rd[23:0], i_dq};
		end
		idle(1);
	end
	endtask : frame
endmodule : ofcd_host
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the octal flash command decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ofcd_pkg::*;
	logic        i_mclk       = 1'b0;
	logic        i_rst        = 1'b1;
	logic        i_dtr_mode   = 1'b0;
	logic [4:0]  i_prot_dummy = 5'h06;
	wire logic   sclk, cs_n, oe, sr, ds, busy, wl, mr;
	wire logic [7:0]  dqi, dqo;
	wire logic [31:0] boot;
	int          miscompares  = 0;
	int          compares     = 0;
	int          pulses       = 0;
	logic [31:0] rd;
	logic        early;
	always #2 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (mr === 1'b1) pulses++;
	ofcd_decoder dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_dq(dqi), .i_dtr_mode(i_dtr_mode), .i_prot_dummy(i_prot_dummy), .o_dq(dqo),
		.o_dq_oe(oe), .o_single_rate(sr), .o_deep_sleep(ds), .o_busy_flag(busy),
		.o_write_latch(wl), .o_mem_reset(mr), .o_boot_reg(boot));
	ofcd_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(dqi), .i_dq(dqo), .i_oe(oe));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
	begin
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	end
	endtask : chk
	task automatic cmd(input logic [7:0] op);
	begin
		host.frame(op, ~op, 0, 0, 32'h0, 0, 0, rd, early);
	end
	endtask : cmd
	// idle the link until busy clears
	task automatic settle;
		int n;
	begin
		for (n = 0; n < 200 && busy !== 1'b0; n++)
			host.idle(1);
		host.idle(2);
		chk("busy end", 0, busy);
	end
	endtask : settle
	task automatic t_boot;
	begin
		host.frame(OP_BOOT_RD, ~OP_BOOT_RD, 4, 0, 0, 4, 4, rd, early);
		chk("boot rd", BOOT_RESET, rd);
		chk("early", 0, early);
		host.frame(OP_BOOT_WR, ~OP_BOOT_WR, 4, 4, 32'h12345678, 0, 0, rd, early);
		chk("no latch", BOOT_RESET, boot);
		chk("no latch busy", 0, busy);
		cmd(OP_WRITE_EN);
		host.frame(OP_BOOT_WR, ~OP_BOOT_WR, 4, 3, 32'h00ABCDEF, 0, 0, rd, early);
		chk("short wr", BOOT_RESET, boot);
		chk("short wr busy", 0, busy);
		host.frame(OP_BOOT_WR, ~OP_BOOT_WR, 4, 4, 32'h12345678, 0, 0, rd, early);
		host.frame(OP_STATUS_RD, ~OP_STATUS_RD, 4, 0, 0, 4, 1, rd, early);
		chk("status", 32'h3, rd);
		settle();
		chk("boot", 32'h12345678, boot);
		chk("latch", 0, wl);
		host.frame(OP_BOOT_RD, ~OP_BOOT_RD, 4, 0, 0, 4, 4, rd, early);
		chk("boot rd", 32'h78563412, rd);
		cmd(OP_WRITE_EN);
		cmd(OP_BOOT_ER);
		settle();
		chk("erase", BOOT_RESET, boot);
	end
	endtask : t_boot
	task automatic t_sleep;
		int m;
	begin
		for (m = 0; m < 2; m++)
		begin
			@(posedge i_mclk) i_dtr_mode <= m[0];
			cmd(OP_SLEEP_ENTER);
			chk("sleep", 1, ds);
			cmd(OP_WRITE_EN);
			chk("sleep wen", 0, wl);
			cmd(OP_SLEEP_EXIT);
			chk("wake", 0, ds);
		end
	end
	endtask : t_sleep
	task automatic t_reset;
		int p;
	begin
		p = pulses;
		cmd(OP_RESET_ARM);
		cmd(OP_RESET_MEM);
		chk("reset", p + 1, pulses);
		cmd(OP_RESET_ARM);
		cmd(OP_WRITE_DIS);
		cmd(OP_RESET_MEM);
		chk("broken pair", p + 1, pulses);
	end
	endtask : t_reset
	task automatic t_regs;
		int d;
	begin
		host.frame(OP_IDENT_RD, ~OP_IDENT_RD, 4, 0, 0, 4, 3, rd, early);
		chk("ident", IDENT_VALUE, rd);
		chk("ident rate", 1, sr);
		host.frame(OP_WRITE_EN, 8'hF8, 0, 0, 0, 0, 0, rd, early);
		chk("bad pair", 0, wl);
		for (d = 6; d <= 20; d += 14)
		begin
			@(posedge i_mclk) i_prot_dummy <= d[4:0];
			host.frame(OP_PERS_PROT_RD, ~OP_PERS_PROT_RD, 4, 0, 0, d, 1, rd, early);
			chk("prot early", 0, early);
			host.frame(OP_DYN_PROT_RD, ~OP_DYN_PROT_RD, 4, 0, 0, d, 1, rd, early);
			chk("prot rd", 0, rd);
			chk("prot rate", 0, sr);
		end
	end
	endtask : t_regs
	task automatic conclude;
	begin
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask : conclude
	initial
	begin
		repeat (2) @(posedge i_mclk);
		host.idle(1);
		@(posedge i_mclk) i_rst <= 1'b0;
		chk("reset boot", BOOT_RESET, boot);
		t_boot();
		t_sleep();
		t_reset();
		t_regs();
		conclude();
	end
	initial
	begin
		#100000;
		miscompares++;
		conclude();
	end
endmodule : testbench
`default_nettype wire
